// >>> design/dfir_defines.svh
`ifndef DFIR_DEFINES_SVH
`define DFIR_DEFINES_SVH

// host write map
`define DFIR_ADDR_CFG0         9'h000
`define DFIR_ADDR_CFG1         9'h001
`define DFIR_COEF_PAGE_BIT     8

// reset values of the two configuration words
`define DFIR_CFG0_RESET        10'h000
`define DFIR_CFG1_RESET        10'h000

// configuration word 0 fields
`define DFIR_CFG0_ODD_SYM_BIT  5
`define DFIR_CFG0_EVEN_LEN_BIT 6
`define DFIR_CFG0_B_INB_BIT    7
`define DFIR_CFG0_SINGLE_BIT   9

// configuration word 1 fields
`define DFIR_CFG1_DATA_UNS_BIT 0
`define DFIR_CFG1_COEF_UNS_BIT 1
`define DFIR_CFG1_NOREV_BIT    4
`define DFIR_CFG1_ROUND_LSB    5
`define DFIR_CFG1_ROUND_MSB    9

// round code n adds one at result bit n + base, codes 0 to 11 valid
`define DFIR_ROUND_CODES       5'h0C
`define DFIR_ROUND_BASE_BIT    5'h08

// cell B weight in the scaled sum
`define DFIR_SCALE_SHIFT       10

`endif

// >>> design/dfir_pkg.sv
package dfir_pkg;

  typedef logic        [9:0]  dfir_word_t;
  typedef logic signed [27:0] dfir_result_t;

  typedef enum logic [1:0] {
    dfir_comb_scaled = 2'h0,
    dfir_comb_sel_a  = 2'h1,
    dfir_comb_sel_b  = 2'h2,
    dfir_comb_sum    = 2'h3
  } dfir_comb_t;

endpackage

// >>> design/dfir_if.sv
`timescale 1ns/10ps

// coefficient bank write and per-clock set read
interface dfir_coef_if;
  logic                    we;
  logic [7:0]              waddr;
  dfir_pkg::dfir_word_t    wdata;
  logic [4:0]              rset;
  dfir_pkg::dfir_word_t    rcoef [8];
  modport user (output we, output waddr, output wdata, output rset, input rcoef);
  modport mem  (input we, input waddr, input wdata, input rset, output rcoef);
endinterface

// result stream into the output buffer
interface dfir_stream_if;
  logic                    valid;
  logic                    ready;
  dfir_pkg::dfir_result_t  data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// >>> design/dfir_coef_mem.sv
`timescale 1ns/10ps

module dfir_coef_mem (
  input  wire logic        ref_clk_in, // core clock
  dfir_coef_if.mem         bank        // write port and set read
);

  dfir_pkg::dfir_word_t store [256];

  always_ff @(posedge ref_clk_in)
  begin
    if (bank.we)
    begin
      store[bank.waddr] <= bank.wdata;
    end
  end

  // all eight coefficients of the chosen set, registered
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_rd
      always_ff @(posedge ref_clk_in)
      begin
        bank.rcoef[i] <= store[{bank.rset, 3'(i)}];
      end
    end
  endgenerate

endmodule

// >>> design/dfir_buf2.sv
`timescale 1ns/10ps

module dfir_buf2 (
  input  wire logic              ref_clk_in,    // core clock
  input  wire logic              rst_in,        // synchronous reset, high
  dfir_stream_if.sink            up,            // results from the output stage
  output logic                   out_valid_out, // head word present
  input  wire logic              out_ready_in,  // receiver takes head word
  output dfir_pkg::dfir_result_t out_data_out   // head word
);

  dfir_pkg::dfir_result_t tail;
  logic [1:0]             cnt;

  wire push = up.valid & up.ready;
  wire pop  = out_valid_out & out_ready_in;

  assign up.ready      = cnt != 2'h2;
  assign out_valid_out = cnt != 2'h0;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cnt          <= 2'h0;
      out_data_out <= '0;
      tail         <= '0;
    end
    else
    begin
      unique case ({push, pop})
        2'b10:
        begin
          if (cnt == 2'h0)
            out_data_out <= up.data;
          else
            tail <= up.data;
          cnt <= 2'(cnt + 2'h1);
        end
        2'b01:
        begin
          out_data_out <= tail;
          cnt          <= 2'(cnt - 2'h1);
        end
        2'b11:
        begin
          if (cnt == 2'h1)
            out_data_out <= up.data;
          else
          begin
            out_data_out <= tail;
            tail         <= up.data;
          end
        end
        2'b00:
        begin
        end
      endcase
    end
  end

endmodule

// >>> design/dfir_top.sv
`timescale 1ns/10ps
`include "dfir_defines.svh"

// How it works
// - accumulator sums the registered multiplier products of its own cell
// - accumulate low: feedback zeroed, accumulator copied into holding register
// - accumulate high: running sum grows, holding register keeps its contents
// - two-bit combine select adds or picks between the holding registers
// - one combine code adds cell B scaled down by 2^10 to cell A
// - data and coefficients each signed or unsigned as configured
// - result unsigned only for even symmetry with unsigned data and coefficients
// - round by adding one at a chosen weight from 2^-10 to 2^1
// - round code for weight 2^-1 keeps result bits 18 to 27
// - result is 28 bits, bit 0 weighs 2^-18, bit 27 is sign
// - two configuration words at 000 and 001, bit 4 disables reversal
// - set 0 coefficients at 100-103 for cell A, 104-107 for B
// - each cell pre-adds sample pairs, eight taps; cascade gives sixteen taps
// - odd length folds one register earlier; host halves centre coefficient
// - pre-adder adds for even symmetry, subtracts forward for odd symmetry
// - coefficient address: bits 1:0 multiplier, bit 2 cell, 7:3 set
// - shift enable high freezes the tap lines; next sample enters on release
// - forward zero or reverse zero clears that pre-adder input
module dfir_top (
  input  wire logic              ref_clk_in,               // core clock
  input  wire logic              rst_in,                   // synchronous reset, high
  input  wire logic [9:0]        host_write_data_in,       // host write data
  input  wire logic [8:0]        host_write_address_in,    // host write address
  input  wire logic              host_write_strobe_in,     // host write, rising edge
  input  wire logic [9:0]        sample_in_a_in,           // sample input A
  input  wire logic [9:0]        sample_in_b_in,           // sample input B
  input  wire logic              accumulate_enable_in,     // keep summing when high
  input  wire logic [1:0]        output_combine_select_in, // cell combine code
  input  wire logic              block_transfer_in,        // feedback path transfer
  input  wire logic              forward_zero_in,          // clear forward operand
  input  wire logic              reverse_zero_in,          // clear backward operand
  input  wire logic              shift_enable_n_in,        // tap lines shift when low
  input  wire logic [4:0]        coef_set_select_in,       // coefficient set in use
  input  wire logic              result_ready_in,          // receiver takes result
  output dfir_pkg::dfir_result_t filter_result_out,        // result word
  output logic                   result_valid_out,         // result word present
  output logic                   result_unsigned_out,      // result format is unsigned
  output logic                   stall_out                 // pipeline held by full buffer
);

  function automatic logic signed [10:0] dfir_ext(input logic [9:0] v, input logic uns);
    return uns ? {1'b0, v} : {v[9], v};
  endfunction

  // host write port
  dfir_pkg::dfir_word_t cfg0;
  dfir_pkg::dfir_word_t cfg1;
  logic [2:0]           wr_sync;
  logic                 wr_level;

  wire wr_agree = wr_sync[1] == wr_sync[2];
  wire wr_rise  = wr_agree & wr_sync[2] & ~wr_level;
  wire hit_cfg0 = wr_rise & (host_write_address_in == `DFIR_ADDR_CFG0);
  wire hit_cfg1 = wr_rise & (host_write_address_in == `DFIR_ADDR_CFG1);
  wire hit_coef = wr_rise & host_write_address_in[`DFIR_COEF_PAGE_BIT];

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      wr_sync  <= 3'h0;
      wr_level <= 1'b0;
    end
    else
    begin
      wr_sync <= {wr_sync[1:0], host_write_strobe_in};
      if (wr_agree)
        wr_level <= wr_sync[2];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cfg0 <= `DFIR_CFG0_RESET;
      cfg1 <= `DFIR_CFG1_RESET;
    end
    else
    begin
      if (hit_cfg0)
        cfg0 <= host_write_data_in;
      if (hit_cfg1)
        cfg1 <= host_write_data_in;
    end
  end

  wire       odd_sym     = cfg0[`DFIR_CFG0_ODD_SYM_BIT];
  wire       even_len    = cfg0[`DFIR_CFG0_EVEN_LEN_BIT];
  wire       b_from_inb  = cfg0[`DFIR_CFG0_B_INB_BIT];
  wire       single_mode = cfg0[`DFIR_CFG0_SINGLE_BIT];
  wire       data_uns    = cfg1[`DFIR_CFG1_DATA_UNS_BIT];
  wire       coef_uns    = cfg1[`DFIR_CFG1_COEF_UNS_BIT];
  wire       no_reverse  = cfg1[`DFIR_CFG1_NOREV_BIT];
  wire [4:0] round_code  = cfg1[`DFIR_CFG1_ROUND_MSB:`DFIR_CFG1_ROUND_LSB];

  // with reversal on, the backward pre-adder operand is zero unless block transfer is high
  wire rev_live = no_reverse | block_transfer_in;

  // coefficient bank, address bits 7:3 set, 2 cell, 1:0 multiplier
  dfir_coef_if cif ();

  assign cif.we    = hit_coef;
  assign cif.waddr = host_write_address_in[7:0];
  assign cif.wdata = host_write_data_in;
  assign cif.rset  = coef_set_select_in;

  dfir_coef_mem u_coef (
    .ref_clk_in (ref_clk_in),
    .bank       (cif)
  );

  // output buffer and pipeline hold
  dfir_stream_if sif ();
  logic          result_v;

  wire stall     = result_v & ~sif.ready;
  wire shift_now = ~stall & ~shift_enable_n_in;

  // tap lines, cascaded end to end in single filter mode
  dfir_pkg::dfir_word_t line_a [8];
  dfir_pkg::dfir_word_t line_b [8];
  dfir_pkg::dfir_word_t full   [16];

  wire [9:0] b_feed = single_mode ? line_a[7] : (b_from_inb ? sample_in_b_in : sample_in_a_in);

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 8; i++)
      begin
        line_a[i] <= 10'h000;
        line_b[i] <= 10'h000;
      end
    end
    else if (shift_now)
    begin
      line_a[0] <= sample_in_a_in;
      line_b[0] <= b_feed;
      for (int i = 1; i < 8; i++)
      begin
        line_a[i] <= line_a[i-1];
        line_b[i] <= line_b[i-1];
      end
    end
  end

  logic signed [11:0] alu_q  [2][4];
  logic signed [22:0] prod_q [2][4];

  genvar c, k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_full
      assign full[k]   = line_a[k];
      assign full[k+8] = line_b[k];
    end

    for (c = 0; c < 2; c++)
    begin : g_cell
      for (k = 0; k < 4; k++)
      begin : g_mul
        wire [9:0]          fwd;
        wire [9:0]          bwd_even;
        wire [9:0]          bwd_odd;
        wire [9:0]          bwd;
        wire signed [10:0]  op_a;
        wire signed [10:0]  op_b;
        wire signed [11:0]  alu;
        wire signed [10:0]  coef;

        // pair taps folded about the centre of the active line
        assign fwd      = single_mode ? full[4*c+k] : full[8*c+k];
        assign bwd_even = single_mode ? full[15-4*c-k] : full[8*c+7-k];
        assign bwd_odd  = single_mode ? full[14-4*c-k] : full[8*c+6-k];
        assign bwd      = even_len ? bwd_even : bwd_odd;
        assign op_a     = forward_zero_in ? 11'sh000 : dfir_ext(fwd, data_uns);
        assign op_b     = (reverse_zero_in | ~rev_live) ? 11'sh000
                        : dfir_ext(bwd, data_uns);
        assign alu      = odd_sym ? 12'(op_b) - 12'(op_a) : 12'(op_b) + 12'(op_a);
        assign coef     = dfir_ext(cif.rcoef[c*4+k], coef_uns);

        // operands wait one clock to meet the registered coefficient read
        always_ff @(posedge ref_clk_in)
        begin
          if (rst_in)
          begin
            alu_q[c][k]  <= 12'sh000;
            prod_q[c][k] <= 23'sh000000;
          end
          else if (!stall)
          begin
            alu_q[c][k]  <= alu;
            prod_q[c][k] <= alu_q[c][k] * coef;
          end
        end
      end
    end
  endgenerate

  // accumulators and holding registers
  dfir_pkg::dfir_result_t acc  [2];
  dfir_pkg::dfir_result_t hold [2];
  logic                   hold_new;

  generate
    for (c = 0; c < 2; c++)
    begin : g_acc
      wire signed [27:0] psum = 28'(prod_q[c][0]) + 28'(prod_q[c][1])
                              + 28'(prod_q[c][2]) + 28'(prod_q[c][3]);
      wire signed [27:0] fbk  = accumulate_enable_in ? acc[c] : 28'sh0000000;

      always_ff @(posedge ref_clk_in)
      begin
        if (rst_in)
        begin
          acc[c]  <= 28'sh0000000;
          hold[c] <= 28'sh0000000;
        end
        else if (!stall)
        begin
          acc[c] <= psum + fbk;
          if (!accumulate_enable_in)
            hold[c] <= acc[c];
        end
      end
    end
  endgenerate

  // combine, round and register the result
  wire out_uns = ~odd_sym & data_uns & coef_uns;

  wire signed [27:0] b_scaled = out_uns ? (hold[1] >> `DFIR_SCALE_SHIFT)
                              : (hold[1] >>> `DFIR_SCALE_SHIFT);
  wire signed [27:0] sum_ab   = hold[0] + hold[1];
  wire signed [27:0] sum_sc   = hold[0] + b_scaled;

  dfir_pkg::dfir_comb_t comb_sel;
  assign comb_sel = dfir_pkg::dfir_comb_t'(output_combine_select_in);

  wire signed [27:0] combined =
    (comb_sel == dfir_pkg::dfir_comb_sel_a) ? hold[0] :
    (comb_sel == dfir_pkg::dfir_comb_sel_b) ? hold[1] :
    (comb_sel == dfir_pkg::dfir_comb_sum)   ? sum_ab  : sum_sc;

  wire        round_on  = round_code < `DFIR_ROUND_CODES;
  wire [4:0]  round_bit = 5'(round_code + `DFIR_ROUND_BASE_BIT);
  wire [27:0] round_add = round_on ? (28'h0000001 << round_bit) : 28'h0000000;

  dfir_pkg::dfir_result_t result_q;
  logic                   result_uns_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      hold_new     <= 1'b0;
      result_v     <= 1'b0;
      result_q     <= 28'sh0000000;
      result_uns_q <= 1'b0;
    end
    else
    begin
      result_uns_q <= out_uns;
      if (!stall)
      begin
        hold_new <= ~accumulate_enable_in;
        result_v <= hold_new;
        result_q <= combined + $signed(round_add);
      end
    end
  end

  assign sif.valid = result_v;
  assign sif.data  = result_q;

  dfir_buf2 u_buf (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .up            (sif),
    .out_valid_out (result_valid_out),
    .out_ready_in  (result_ready_in),
    .out_data_out  (filter_result_out)
  );

  assign result_unsigned_out = result_uns_q;
  assign stall_out           = stall;

endmodule

// >>> tb/dfir_monitor.sv
`timescale 1ns/10ps

module dfir_monitor (
  input wire logic                   ref_clk_in,           // core clock
  input wire logic                   rst_in,               // reset, high
  input wire logic                   host_write_strobe_in, // write strobe
  input wire logic                   accumulate_enable_in, // accumulate
  input wire logic                   result_ready_in,      // sink ready
  input wire dfir_pkg::dfir_result_t filter_result_out,    // result word
  input wire logic                   result_valid_out,     // word present
  input wire logic                   result_unsigned_out,  // format flag
  input wire logic                   stall_out             // pipeline held
);
  logic [5:0] acc_hist;
  logic [3:0] wr_age;
  logic [4:0] hi_run;
  logic [4:0] lo_run;
  wire        hi_clr = rst_in || !accumulate_enable_in || !result_ready_in;
  wire        lo_clr = rst_in || accumulate_enable_in;

  always_ff @(posedge ref_clk_in)
  begin
    acc_hist <= {acc_hist[4:0], accumulate_enable_in};
    wr_age   <= (rst_in || wr_age == 4'hF) ? 4'hF : wr_age + 4'h1;
    if (host_write_strobe_in)
      wr_age <= 4'h0;
    hi_run   <= hi_clr ? 5'h00 : hi_run + {4'h0, hi_run != 5'h1F};
    lo_run   <= lo_clr ? 5'h00 : lo_run + {4'h0, lo_run != 5'h1F};
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_reset_clears_out: assert property ($fell(rst_in) |->
    filter_result_out == 28'h0000000 && !result_unsigned_out && !stall_out)
    else $error("outputs not cleared by reset");
  a_fill_takes_time: assert property ($fell(rst_in) |-> !result_valid_out [*3])
    else $error("result word appeared too early after reset");
  a_head_word_holds: assert property (result_valid_out && !result_ready_in |=>
    result_valid_out && $stable(filter_result_out))
    else $error("unaccepted result word changed");
  a_stall_means_full: assert property (stall_out |-> result_valid_out)
    else $error("stall with empty output buffer");
  a_word_needs_dump: assert property ($rose(result_valid_out) |-> acc_hist != 6'h3F)
    else $error("result word without an accumulator dump");
  a_accum_stays_quiet: assert property (hi_run >= 5'h0C |-> !result_valid_out)
    else $error("result words while accumulating");
  a_dump_gives_words: assert property (lo_run >= 5'h0A |-> result_valid_out)
    else $error("no result words while dumping every clock");
  a_format_on_write: assert property ($changed(result_unsigned_out) |-> wr_age < 4'h8)
    else $error("format flag changed without a write");

  c_stall: cover property (stall_out);
  c_unsigned: cover property ($rose(result_unsigned_out));
  c_pop: cover property (result_valid_out && result_ready_in);
endmodule

bind dfir_top dfir_monitor mon (.ref_clk_in, .rst_in, .host_write_strobe_in,
  .accumulate_enable_in, .result_ready_in, .filter_result_out, .result_valid_out,
  .result_unsigned_out, .stall_out);

// >>> tb/dfir_host_model.sv
`timescale 1ns/10ps

module dfir_host_model (
  input  wire logic ref_clk_in, // core clock
  output logic [8:0] addr_out,  // write address
  output logic [9:0] data_out,  // write data
  output logic       strobe_out // write strobe
);
  initial
  begin
    addr_out   = 9'h000;
    data_out   = 10'h000;
    strobe_out = 1'b0;
  end

  // five clocks high and four low so the three-stage synchroniser sees every edge
  task automatic wr(input logic [8:0] a, input logic [9:0] d);
    @(posedge ref_clk_in);
    #1;
    addr_out   = a;
    data_out   = d;
    strobe_out = 1'b1;
    repeat (5) @(posedge ref_clk_in);
    #1;
    strobe_out = 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
endmodule

// >>> tb/test_dual_fir_accumulate_output_stage.sv
`timescale 1ns/10ps

module test_dual_fir_accumulate_output_stage;
  logic                   ref_clk_in = 1'b0;
  logic                   rst_in = 1'b1;
  logic [9:0]             host_write_data_in;
  logic [8:0]             host_write_address_in;
  logic                   host_write_strobe_in;
  logic [9:0]             sample_in_a_in = 10'h000;
  logic [9:0]             sample_in_b_in = 10'h000;
  logic                   accumulate_enable_in = 1'b0;
  logic [1:0]             output_combine_select_in = 2'h1;
  logic                   forward_zero_in = 1'b0;
  logic                   reverse_zero_in = 1'b0;
  logic [4:0]             coef_set_select_in = 5'h00;
  logic                   result_ready_in = 1'b1;
  dfir_pkg::dfir_result_t filter_result_out;
  logic                   result_valid_out;
  logic                   result_unsigned_out;
  logic                   stall_out;
  logic                   stall_seen = 1'b0;
  logic                   shift_enable_n_in = 1'b0;
  logic                   freeze = 1'b0;
  int                     fail_count = 0;
  int                     cmp_count = 0;
  int                     cyc = 0;
  logic [27:0]            got[$];
  logic [9:0]             ca[2][4] = '{'{10'h001, 10'h002, 10'h003, 10'h004},
                                       '{10'h005, 10'h006, 10'h007, 10'h008}};
  logic [9:0]             cb[4] = '{10'h100, 10'h200, 10'h300, 10'h3FF};

  always #2 ref_clk_in = ~ref_clk_in;

  dfir_host_model host (.ref_clk_in, .addr_out(host_write_address_in),
    .data_out(host_write_data_in), .strobe_out(host_write_strobe_in));

  dfir_top dut (.ref_clk_in, .rst_in, .host_write_data_in, .host_write_address_in,
    .host_write_strobe_in, .sample_in_a_in, .sample_in_b_in, .accumulate_enable_in,
    .output_combine_select_in, .block_transfer_in(1'b0), .forward_zero_in,
    .reverse_zero_in, .shift_enable_n_in, .coef_set_select_in, .result_ready_in,
    .filter_result_out, .result_valid_out, .result_unsigned_out, .stall_out);

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [27:0] seen, input logic [27:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  function automatic int sx(input logic [9:0] v, input logic u);
    return u ? int'(v) : int'($signed(v));
  endfunction

  // configure, send one impulse on both inputs, then compare the popped words
  task automatic run(input logic [1:0] m, input logic [9:0] w0, input logic [9:0] w1,
                     input logic s, input logic [1:0] z, input int xa, input bit hold);
    int e[16];
    int a;
    int b;
    int r;
    int k;
    int i;
    int f;
    int q;
    int h;
    host.wr(9'h000, w0);
    host.wr(9'h001, w1);
    tick(1);
    check({27'h0, result_unsigned_out}, {27'h0, w1[0] & w1[1] & !w0[5]}, "format");
    r = (w1[9:5] < 5'h0C) ? (1 << (w1[9:5] + 8)) : 0;
    h = w0[9] ? 8 : 4;
    for (k = 0; k < 16; k++)
    begin
      // q is the tap index seen by the coefficient, single mode spans both cells
      q = (k < h) ? k : 2 * h - 2 + int'(w0[6]) - k;
      i = q & 3;
      f = (k >= 2 * h || (!w0[6] && k == 7)) ? 0 : (k < h && w0[5]) ? -1 : 1;
      if (!w0[6] && k == 3)
        f = w0[5] ? 0 : 2;
      a = (w0[9] && q > 3) ? 0 : sx(xa[9:0], w1[0]) * sx(ca[s][i], w1[1]) * f;
      b = (w0[9] && q < 4) ? 0
        : sx(w0[9] ? xa[9:0] : 10'h3FF, w1[0]) * sx(cb[i], w1[1]) * f;
      if ((k < h) ? z[0] : (z[1] | ~w1[4]))
      begin
        a = 0;
        b = 0;
      end
      e[k] = (m == 2'h0) ? a + (b >>> 10) : (m == 2'h1) ? a : (m == 2'h2) ? b : a + b;
      e[k] += r;
    end
    output_combine_select_in = m;
    coef_set_select_in = {4'h0, s};
    forward_zero_in = z[0];
    reverse_zero_in = z[1];
    stall_seen = 1'b0;
    tick(20);
    got.delete();
    sample_in_a_in = xa[9:0];
    sample_in_b_in = 10'h3FF;
    if (freeze)
    begin
      // held samples must not enter while the tap lines are frozen
      shift_enable_n_in = 1'b1;
      tick(3);
      shift_enable_n_in = 1'b0;
    end
    tick(1);
    sample_in_a_in = 10'h000;
    sample_in_b_in = 10'h000;
    if (hold)
    begin
      tick(4);
      result_ready_in = 1'b0;
      tick(12);
      result_ready_in = 1'b1;
      check({27'h0, stall_seen}, 28'h0000001, "stall");
    end
    tick(30);
    k = 0;
    while (k < 16 && e[k] == r)
      k++;
    while (got.size() > 0 && got[0] === 28'(r))
      void'(got.pop_front());
    for (; k < 16; k++)
      check(got.size() > 0 ? got.pop_front() : 28'hXXXXXXX, 28'(e[k]), "word");
    check(got.size() > 0 ? got[0] : 28'hXXXXXXX, 28'(r), "idle word");
  endtask

  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (!rst_in && result_valid_out === 1'b1 && result_ready_in)
      got.push_back(filter_result_out);
    if (stall_out === 1'b1)
      stall_seen = 1'b1;
    if (cyc == 3000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    tick(8);
    rst_in = 1'b0;
    tick(1);
    check(filter_result_out, 28'h0000000, "reset word");
    check({25'h0, result_valid_out, result_unsigned_out, stall_out}, 28'h0, "reset flags");
    for (int n = 0; n < 4; n++)
    begin
      host.wr(9'h100 + 9'(n), ca[0][n]);
      host.wr(9'h104 + 9'(n), cb[n]);
      host.wr(9'h108 + 9'(n), ca[1][n]);
    end
    run(2'h1, 10'h1D0, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    host.wr(9'h002, 10'h000);
    host.wr(9'h0FF, 10'h000);
    tick(1);
    check({27'h0, result_unsigned_out}, 28'h0000001, "unmapped write");
    run(2'h2, 10'h1D0, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    run(2'h3, 10'h1D0, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    run(2'h0, 10'h1D0, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    run(2'h1, 10'h1D0, 10'h133, 1'b0, 2'h0, 3, 1'b0);
    run(2'h1, 10'h1D0, 10'h013, 1'b0, 2'h0, 3, 1'b0);
    run(2'h1, 10'h1D0, 10'h173, 1'b0, 2'h0, 3, 1'b0);
    run(2'h1, 10'h1D0, 10'h3F3, 1'b1, 2'h0, 3, 1'b1);
    run(2'h1, 10'h1D0, 10'h3F3, 1'b0, 2'h1, 3, 1'b0);
    run(2'h1, 10'h1D0, 10'h3F3, 1'b0, 2'h2, 3, 1'b0);
    run(2'h1, 10'h1D0, 10'h3F0, 1'b0, 2'h0, -2, 1'b0);
    run(2'h1, 10'h1F0, 10'h3F0, 1'b0, 2'h0, 3, 1'b0);
    run(2'h1, 10'h190, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    run(2'h3, 10'h3D0, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    run(2'h0, 10'h3D0, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    run(2'h1, 10'h1D0, 10'h3E3, 1'b0, 2'h0, 3, 1'b0);
    freeze = 1'b1;
    run(2'h1, 10'h1D0, 10'h3F3, 1'b0, 2'h0, 3, 1'b0);
    freeze = 1'b0;
    accumulate_enable_in = 1'b1;
    tick(16);
    check({27'h0, result_valid_out}, 28'h0000000, "accumulating");
    accumulate_enable_in = 1'b0;
    tick(12);
    check({27'h0, result_valid_out}, 28'h0000001, "dumping");
    give_verdict();
  end
endmodule
